// file: hw/gpio_port_map.vh
// constants for the six-bit general-purpose port
// Overview of operation
// - six pins, each input or output except input-only pin three
// - direction one disables the output driver; pins zero and four still drive while their function is enabled
// - direction zero drives pin from latch
// - input-only pin direction always reads one
// - reads return pins, writes reach latch
// - port data writes are read-modify-write
// - direction controls drivers even in analog
// - analog select forces digital reads zero
// - analog select never blocks digital output
// - analog select bits set after reset
// - analog functions active only in analog
// - highest priority enabled function owns pin
// - pin zero programming data, pin four clock
// - output priority same in analog mode
// - upper two register bits read zero
// - direction bits reset to one
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH
`define PORT_WIDTH 6
`define REG_WIDTH 8
`define DIR_RESET 6'h3f
`define ANALOG_RESET 6'h3f
`define LATCH_RESET 6'h00
`define INPUT_ONLY_BIT 3
`define PIN_ZERO_BIT 0
`define PIN_FOUR_BIT 4
`endif

// file: hw/pin_sync.v
// two-flop synchroniser for the port pin levels
`include "gpio_port_map.vh"
module pin_sync (
	// clock and reset
	input wire core_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	// raw and synchronised levels
	input wire [`PORT_WIDTH-1:0] pin_raw_in,
	output reg [`PORT_WIDTH-1:0] pin_sync_out
);
	reg [`PORT_WIDTH-1:0] stage1_r;
	// first stage feeds only the second stage
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage1_r <= {`PORT_WIDTH{1'b0}};
			pin_sync_out <= {`PORT_WIDTH{1'b0}};
		end else if (clk_en_in) begin
			stage1_r <= pin_raw_in;
			pin_sync_out <= stage1_r;
		end
	end
endmodule

// file: hw/six_bit_gpio_port.v
// six-bit bidirectional port with latch, direction, analog select and output priority
`include "gpio_port_map.vh"
module six_bit_gpio_port (
	// clock, reset, enable
	input wire core_clk_in,
	input wire rst_in,
	input wire clk_en_in,
	// port data register access
	input wire pin_value_reg_wr_in,
	input wire [`REG_WIDTH-1:0] pin_value_reg_wdata_in,
	input wire [`REG_WIDTH-1:0] pin_value_reg_wmask_in,
	output reg [`REG_WIDTH-1:0] pin_value_reg_out,
	// output latch access
	input wire output_latch_wr_in,
	input wire [`REG_WIDTH-1:0] output_latch_wdata_in,
	output reg [`REG_WIDTH-1:0] output_latch_out,
	// direction register access
	input wire direction_reg_wr_in,
	input wire [`REG_WIDTH-1:0] direction_reg_wdata_in,
	output reg [`REG_WIDTH-1:0] direction_reg_out,
	// analog select register access
	input wire analog_select_reg_wr_in,
	input wire [`REG_WIDTH-1:0] analog_select_reg_wdata_in,
	output reg [`REG_WIDTH-1:0] analog_select_reg_out,
	// peripheral output functions
	input wire programming_data_function_en_in,
	input wire programming_data_function_in,
	input wire clock_output_function_en_in,
	input wire clock_output_function_in,
	// pins
	input wire [`PORT_WIDTH-1:0] pin_in,
	output reg [`PORT_WIDTH-1:0] pin_out,
	output reg [`PORT_WIDTH-1:0] pin_oe_out,
	// analog enables per pin
	output reg [`PORT_WIDTH-1:0] analog_enable_out
);
	reg [`PORT_WIDTH-1:0] latch_r;
	reg [`PORT_WIDTH-1:0] latch_nxt;
	reg [`PORT_WIDTH-1:0] dir_r;
	reg [`PORT_WIDTH-1:0] dir_nxt;
	reg [`PORT_WIDTH-1:0] ansel_r;
	wire [`PORT_WIDTH-1:0] drive_val;
	wire [`PORT_WIDTH-1:0] drive_en;
	wire [`PORT_WIDTH-1:0] pin_sync;
	wire [`PORT_WIDTH-1:0] digital_read;

	pin_sync u_pin_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.pin_raw_in(pin_in),
		.pin_sync_out(pin_sync)
	);

	// analog pins read zero; this also feeds the read-modify-write merge,
	// so an analog pin driven high loses its latch bit on a masked port write
	assign digital_read = pin_sync & ~ansel_r;

	// latch update: port writes merge the read value with unmasked bits
	always @* begin
		latch_nxt = latch_r;
		if (output_latch_wr_in) begin
			latch_nxt = output_latch_wdata_in[`PORT_WIDTH-1:0];
		end
		if (pin_value_reg_wr_in) begin
			latch_nxt = (digital_read & ~pin_value_reg_wmask_in[`PORT_WIDTH-1:0]) |
				(pin_value_reg_wdata_in[`PORT_WIDTH-1:0] & pin_value_reg_wmask_in[`PORT_WIDTH-1:0]);
		end
	end

	always @* begin
		dir_nxt = dir_r;
		if (direction_reg_wr_in) begin
			dir_nxt = direction_reg_wdata_in[`PORT_WIDTH-1:0];
		end
		dir_nxt[`INPUT_ONLY_BIT] = 1'b1;
	end

	// output priority per pin, independent of analog select
	genvar i;
	generate
		for (i = 0; i < `PORT_WIDTH; i = i + 1) begin : g_pin
			// one continuous driver per bit keeps each net single-driven
			if (i == `PIN_ZERO_BIT) begin : g_prog
				assign drive_val[i] = programming_data_function_en_in ? programming_data_function_in : latch_r[i];
				assign drive_en[i] = programming_data_function_en_in | ~dir_r[i];
			end else if (i == `PIN_FOUR_BIT) begin : g_clk
				assign drive_val[i] = clock_output_function_en_in ? clock_output_function_in : latch_r[i];
				assign drive_en[i] = clock_output_function_en_in | ~dir_r[i];
			end else if (i == `INPUT_ONLY_BIT) begin : g_in
				assign drive_val[i] = 1'b0;
				assign drive_en[i] = 1'b0;
			end else begin : g_io
				assign drive_val[i] = latch_r[i];
				assign drive_en[i] = ~dir_r[i];
			end
		end
	endgenerate

	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch_r <= `LATCH_RESET;
			dir_r <= `DIR_RESET;
			ansel_r <= `ANALOG_RESET;
			pin_out <= {`PORT_WIDTH{1'b0}};
			pin_oe_out <= {`PORT_WIDTH{1'b0}};
			analog_enable_out <= {`PORT_WIDTH{1'b0}};
			pin_value_reg_out <= {`REG_WIDTH{1'b0}};
			output_latch_out <= {`REG_WIDTH{1'b0}};
			direction_reg_out <= {`REG_WIDTH{1'b0}};
			analog_select_reg_out <= {`REG_WIDTH{1'b0}};
		end else if (clk_en_in) begin
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			if (analog_select_reg_wr_in) begin
				ansel_r <= analog_select_reg_wdata_in[`PORT_WIDTH-1:0];
			end
			pin_out <= drive_val;
			pin_oe_out <= drive_en;
			analog_enable_out <= ansel_r;
			pin_value_reg_out <= {2'b00, digital_read};
			output_latch_out <= {2'b00, latch_r};
			direction_reg_out <= {2'b00, dir_r};
			analog_select_reg_out <= {2'b00, ansel_r};
		end
	end
endmodule

// file: verif/gpio_port_assertions.sv
// checker on the six-bit port outputs
module gpio_port_assertions (
	input wire core_clk_in, rst_in, programming_data_function_en_in, programming_data_function_in,
	input wire clock_output_function_en_in, clock_output_function_in,
	input wire [7:0] pin_value_reg_out, output_latch_out, direction_reg_out, analog_select_reg_out,
	input wire [5:0] pin_out, pin_oe_out, analog_enable_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_reset_vals: assert property ($fell(rst_in) |=> direction_reg_out == 8'h3f && analog_select_reg_out == 8'h3f)
		else $error("reset values");
	a_dir_fixed: assert property (!$past(rst_in) |-> direction_reg_out[7:6] == 2'h0 && direction_reg_out[3])
		else $error("direction bits");
	a_oe_dir: assert property (!$past(rst_in) |-> pin_oe_out[3:1] == {1'b0, ~direction_reg_out[2:1]})
		else $error("driver enable");
	a_pin_latch: assert property (pin_oe_out[1] |-> pin_out[1] == output_latch_out[1])
		else $error("pin drive");
	a_read_zero: assert property ((pin_value_reg_out & analog_select_reg_out) == 8'h00)
		else $error("analog read");
	a_analog_en: assert property (!$past(rst_in) |-> analog_enable_out == analog_select_reg_out[5:0])
		else $error("analog enable");
	a_prog_over: assert property (programming_data_function_en_in |=> pin_oe_out[0] && pin_out[0] == $past(programming_data_function_in))
		else $error("override");
	a_clk_over: assert property (clock_output_function_en_in |=> pin_oe_out[4] && pin_out[4] == $past(clock_output_function_in))
		else $error("clock override");
	a_top_zero: assert property (output_latch_out[7:6] == 2'h0 && pin_value_reg_out[7:6] == 2'h0)
		else $error("upper bits");
endmodule
bind six_bit_gpio_port gpio_port_assertions i_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.programming_data_function_en_in(programming_data_function_en_in),
	.programming_data_function_in(programming_data_function_in),
	.clock_output_function_en_in(clock_output_function_en_in),
	.clock_output_function_in(clock_output_function_in),
	.pin_value_reg_out(pin_value_reg_out), .output_latch_out(output_latch_out),
	.direction_reg_out(direction_reg_out), .analog_select_reg_out(analog_select_reg_out),
	.pin_out(pin_out), .pin_oe_out(pin_oe_out), .analog_enable_out(analog_enable_out));

// file: verif/pin_model.sv
// far side: the port drives where enabled, outside drivers elsewhere
module pin_model (input wire [5:0] drv_in, oe_in, ext_in, output wire [5:0] level_out);
	timeunit 1ns;
	timeprecision 1ps;
	assign level_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

// file: verif/tb_top.sv
// bench for the six-bit port
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 0, rst_in = 1, pe = 0, pd = 0, ce = 0, cd = 0;
	logic [3:0] we = 0;
	logic [7:0] wd = 0, wm = 0, pv, lo, dr, an;
	logic [5:0] ext = 0, pin, po, oe, ae;
	int miscompares = 0, n_compared = 0;
	always #10 core_clk_in = ~core_clk_in;
	pin_model i_pins (.drv_in(po), .oe_in(oe), .ext_in(ext), .level_out(pin));
	six_bit_gpio_port i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
		.pin_value_reg_wr_in(we[0]), .pin_value_reg_wdata_in(wd), .pin_value_reg_wmask_in(wm), .pin_value_reg_out(pv),
		.output_latch_wr_in(we[1]), .output_latch_wdata_in(wd), .output_latch_out(lo),
		.direction_reg_wr_in(we[2]), .direction_reg_wdata_in(wd), .direction_reg_out(dr),
		.analog_select_reg_wr_in(we[3]), .analog_select_reg_wdata_in(wd), .analog_select_reg_out(an),
		.programming_data_function_en_in(pe), .programming_data_function_in(pd),
		.clock_output_function_en_in(ce), .clock_output_function_in(cd),
		.pin_in(pin), .pin_out(po), .pin_oe_out(oe), .analog_enable_out(ae));
	task chk(input logic [11:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one strobe, then settle past the three-stage read path
	task wr(input int s, input logic [7:0] d, m);
		we[s] = 1;
		wd = d;
		wm = m;
		@(negedge core_clk_in);
		we = 0;
		repeat (6) @(negedge core_clk_in);
	endtask
	task close_out;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge core_clk_in);
		rst_in = 0;
		repeat (2) @(negedge core_clk_in);
		chk({dr[5:0], an[5:0]}, 12'hfff);
		chk({ae, lo[5:0]}, 12'hfc0);
		chk({oe, pv[5:0]}, 12'h000);
		$display("reset test done");
		ext = 6'h08;
		wr(3, 8'h00, 0);
		wr(2, 8'hc0, 0);
		wr(1, 8'hd5, 0);
		chk(dr, 8'h08);
		chk({oe, 2'h0}, 8'hdc);
		chk(pv, 8'h1d);
		wr(0, 8'hff, 8'h22);
		chk(lo, 8'h3f);
		chk(ae, 6'h00);
		$display("data test done");
		wr(3, 8'hff, 0);
		chk({pv[5:0], oe}, 12'h037);
		chk(po & oe, 6'h37);
		chk({ae, an[5:0]}, 12'hfff);
		wr(2, 8'h3f, 0);
		pe = 1;
		ce = 1;
		repeat (2) @(negedge core_clk_in);
		chk({po & oe, oe}, 12'h011);
		pd = 1;
		cd = 1;
		repeat (2) @(negedge core_clk_in);
		chk({po & oe, oe}, 12'h451);
		$display("override test done");
		close_out;
	end
endmodule
